// ===== hw/wit_top.sv
// Watch timer and interval timer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "wit_consts.svh"

// How it works
// - Mode register resets zero, byte readable/writable
// - Bit 7 picks clock, bits 6:4 interval
// - Bits 3:2 pick watch period 2^14..2^4
// - Run bit starts; clearing stops and clears counter
// - Enable low stops, clears prescaler and counter
// - Watch counting needs run and enable both set
// - Clearing run resets counter, prescaler keeps running
// - Divided main clock gated by main enable
// - Divided clock is main over 2^(m+1)*N
// - Watch interrupt repeats each watch period
// - Watch counter clocked by fw or fw/2^9
// - Interval interrupt repeats independently of watch
// - Divide field picks main over 1,2,4,8
module wit_top #(
  parameter int ADDR_W = 28
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Subclock pin
  input  wire logic              subclk_in,
  // Interrupt requests
  output logic                   watch_irq,
  output logic                   interval_irq,
  output logic                   irq
);
  import wit_pkg::*;

  // Decoding below needs the full 28-bit register address
  if (ADDR_W < 28) begin : g_chk
    $error("wit_top: ADDR_W must be at least 28");
  end

  // Register indices returned by the decoder
  localparam logic [2:0] IDX_MODE  = 3'h0;
  localparam logic [2:0] IDX_PRSM  = 3'h1;
  localparam logic [2:0] IDX_CMP   = 3'h2;
  localparam logic [2:0] IDX_STAT  = 3'h3;
  localparam logic [2:0] IDX_MASK  = 3'h4;
  localparam logic [2:0] IDX_COUNT = 3'h5;
  localparam logic [2:0] IDX_NONE  = 3'h7;

  // State after reset
  localparam wit_state_t ST_RST = '{
    mode:    `WIT_MODE_RST,
    prsm:    `WIT_PRSM_RST,
    cmp:     `WIT_CMP_RST,
    mask:    `WIT_MASK_RST,
    wr:      WIT_WR_IDLE,
    rd:      WIT_RD_IDLE,
    default: '0
  };

  // Address decoder shared by both channels
  // Low two address bits are dropped, so any byte of a word selects it
  function automatic logic [2:0] reg_idx(input logic [ADDR_W-1:0] a);
    logic [27:0] w;
    w = {a[27:2], 2'b00};
    if (w == `WIT_OFS_MODE) begin
      reg_idx = IDX_MODE;
    end else if (w == `WIT_OFS_PRSM) begin
      reg_idx = IDX_PRSM;
    end else if (w == `WIT_OFS_CMP) begin
      reg_idx = IDX_CMP;
    end else if (w == `WIT_OFS_STAT) begin
      reg_idx = IDX_STAT;
    end else if (w == `WIT_OFS_MASK) begin
      reg_idx = IDX_MASK;
    end else if (w == `WIT_OFS_COUNT) begin
      reg_idx = IDX_COUNT;
    end else begin
      reg_idx = IDX_NONE;
    end
  endfunction

  // True when the low n bits of v are all ones
  // Interval, watch and slow-clock compares go through this one mask builder; the prescaler compare does not
  function automatic logic low_ones(input logic [10:0] v, input logic [3:0] n);
    logic [10:0] m;
    m = (11'h001 << n) - 11'h001;
    return (v & m) == m;
  endfunction

  wit_state_t st;         // Registered state
  wit_state_t nx;         // Next state
  logic       oe;         // operation_enable
  logic       run;        // counter_run
  logic       src_tick;   // One cycle of compare_source_clock
  logic       brg_tick;   // Rising edge of divided main clock
  logic       sub_rise;   // Rising edge of subclock
  logic       fw_tick;    // One watch_clock period
  logic       slow_tick;  // One watch_clock/2^9 period
  logic       wclk;       // Watch counter count enable
  logic       intv_hit;   // Interval period expired
  logic       watch_hit;  // Watch period expired
  logic       wr_take;    // Write address and data taken
  logic       rd_take;    // Read address taken

  // Clock tree of the timer: main divider, subclock edge, fw selection
  always_comb begin
    logic [2:0] dmask;
    dmask    = (3'h1 << st.prsm[`WIT_DIV_HI:`WIT_DIV_LO]) - 3'h1;
    oe       = st.mode[`WIT_OE_BIT];
    run      = st.mode[`WIT_RUN_BIT];
    // Source clock is main over 1, 2, 4 or 8, only while enabled
    src_tick = st.prsm[`WIT_MCE_BIT] && ((st.src_div & dmask) == dmask);
    // Halver rises once every 2*N source ticks; N of zero acts as 256
    brg_tick = src_tick && (st.cmp_cnt == st.cmp - 8'h01) && !st.brg_half;
    sub_rise = st.sub_sync[1] && !st.sub_sync[2];
    fw_tick  = st.mode[`WIT_FWSRC_BIT] ? brg_tick : sub_rise;
    // Watch counter runs on fw for short periods, on fw/2^9 for long ones
    slow_tick = fw_tick && low_ones(st.pre, `WIT_WSLOW_EXP);
    wclk      = st.mode[`WIT_WSEL_HI] ? fw_tick : slow_tick;
    intv_hit  = oe && fw_tick &&
                low_ones(st.pre, {1'b0, st.mode[`WIT_ISEL_HI:`WIT_ISEL_LO]} + `WIT_INTV_BASE);
    watch_hit = oe && run && wclk &&
                low_ones({6'h00, st.wcnt},
                         st.mode[`WIT_WSEL_LO] ? `WIT_WFAST_BITS : `WIT_WFULL_BITS);
  end

  // Bus handshakes come from the channel states; the write readies also wait for both valids
  // Address and data are taken in one cycle, so both readies rise together
  assign wr_take = (st.wr == WIT_WR_IDLE) && awvalid && wvalid;
  assign rd_take = (st.rd == WIT_RD_IDLE) && arvalid;
  assign awready = wr_take;
  assign wready  = wr_take;
  assign bvalid  = (st.wr == WIT_WR_RESP);
  assign arready = (st.rd == WIT_RD_IDLE);
  assign rvalid  = (st.rd == WIT_RD_DATA);

  // Outputs from the registered state
  assign bresp        = st.bresp;
  assign rdata        = st.rdata;
  assign rresp        = st.rresp;
  assign watch_irq    = st.watch_p;
  assign interval_irq = st.intv_p;
  assign irq          = |(st.stat & st.mask);

  // Next-state logic of the whole block
  always_comb begin
    logic [2:0] widx;
    logic [2:0] ridx;
    logic [1:0] w1c;
    widx = reg_idx(awaddr);
    ridx = reg_idx(araddr);
    w1c  = 2'h0;
    nx   = st;

    // Subclock pin passes two flops before the edge stage looks at it
    // The pin must stay slower than half of aclk or edges are lost
    nx.sub_sync = {st.sub_sync[1:0], subclk_in};

    // Main clock prescaler and compare counter, held clear while gated off
    if (!st.prsm[`WIT_MCE_BIT]) begin
      nx.src_div  = 3'h0;
      nx.cmp_cnt  = 8'h00;
      nx.brg_half = 1'b0;
    end else begin
      nx.src_div = st.src_div + 3'h1;
      if (src_tick) begin
        if (st.cmp_cnt == st.cmp - 8'h01) begin
          nx.cmp_cnt  = 8'h00;
          nx.brg_half = !st.brg_half;
        end else begin
          nx.cmp_cnt = st.cmp_cnt + 8'h01;
        end
      end
    end

    // Control bits act from the edge after the write that changes them
    // 11-bit prescaler runs whenever operation is enabled
    if (!oe) begin
      nx.pre = 11'h000;
    end else if (fw_tick) begin
      nx.pre = st.pre + 11'h001;
    end

    // 5-bit watch counter needs both control bits
    if (!(oe && run)) begin
      nx.wcnt = 5'h00;
    end else if (wclk) begin
      nx.wcnt = st.wcnt + 5'h01;
    end

    // Expiries become single-cycle pulses
    nx.watch_p = watch_hit;
    nx.intv_p  = intv_hit;

    // Register writes; all writable registers live in byte lane 0
    if (wr_take) begin
      nx.wr    = WIT_WR_RESP;
      nx.bresp = (widx == IDX_NONE) ? `WIT_RESP_DECERR : `WIT_RESP_OKAY;
      if (wstrb[0]) begin
        if (widx == IDX_MODE) begin
          nx.mode = wdata[7:0];
        end else if (widx == IDX_PRSM) begin
          nx.prsm = wdata[7:0];
        end else if (widx == IDX_CMP) begin
          nx.cmp = wdata[7:0];
        end else if (widx == IDX_STAT) begin
          w1c = wdata[1:0];
        end else if (widx == IDX_MASK) begin
          nx.mask = wdata[1:0];
        end
      end
    end else if ((st.wr == WIT_WR_RESP) && bready) begin
      nx.wr = WIT_WR_IDLE;
    end

    // Sticky status: a new event outlives a clear in the same cycle
    nx.stat = (st.stat & ~w1c) | {intv_hit, watch_hit};

    // Register reads
    if (rd_take) begin
      nx.rd    = WIT_RD_DATA;
      nx.rresp = `WIT_RESP_OKAY;
      if (ridx == IDX_MODE) begin
        nx.rdata = {24'h000000, st.mode};
      end else if (ridx == IDX_PRSM) begin
        nx.rdata = {24'h000000, st.prsm};
      end else if (ridx == IDX_CMP) begin
        nx.rdata = {24'h000000, st.cmp};
      end else if (ridx == IDX_STAT) begin
        nx.rdata = {30'h0, st.stat};
      end else if (ridx == IDX_MASK) begin
        nx.rdata = {30'h0, st.mask};
      end else if (ridx == IDX_COUNT) begin
        nx.rdata = {11'h000, st.wcnt, 5'h00, st.pre};
      end else begin
        nx.rdata = 32'h00000000;
        nx.rresp = `WIT_RESP_DECERR;
      end
    end else if ((st.rd == WIT_RD_DATA) && rready) begin
      nx.rd = WIT_RD_IDLE;
    end
  end

  // State register
  // Synchronous reset brings the whole struct back to its reset image
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  // Checks on the timer behaviour
  // All checks sample on aclk and rest while reset is held
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mode_reset_a: assert property ($rose(aresetn) |-> st.mode == 8'h00 && !irq)
    else $error("mode register not zero after reset");

  off_clears_a: assert property (!oe |=> st.pre == 11'h000 && st.wcnt == 5'h00)
    else $error("disable did not clear prescaler and counter");

  run_clears_a: assert property (oe && !run |=> st.wcnt == 5'h00)
    else $error("run low did not clear watch counter");

  watch_needs_a: assert property (watch_irq |-> $past(oe && run))
    else $error("watch pulse without run and enable");

  pre_keeps_a: assert property (oe && !run && fw_tick |=> st.pre == $past(st.pre) + 11'h001)
    else $error("prescaler stalled while run was low");

  brg_gate_a: assert property (!st.prsm[`WIT_MCE_BIT] |=> st.cmp_cnt == 8'h00 && !st.brg_half)
    else $error("divided clock running while gated");

  pulse_single_a: assert property ((watch_irq || interval_irq) |=> !(watch_irq || interval_irq))
    else $error("interrupt pulse longer than one cycle");

  irq_level_a: assert property (watch_irq && st.mask[`WIT_ST_WATCH] |-> irq ##1 irq)
    else $error("unmasked watch event did not raise irq");

  intv_sel_a: assert property (interval_irq |-> $past(low_ones(st.pre, 4'h4) && oe))
    else $error("interval pulse off a prescaler boundary");

  // Status must record every event that a pulse line announces
  watch_stat_a: assert property (watch_irq |-> st.stat[`WIT_ST_WATCH])
    else $error("watch pulse without status bit");

  intv_stat_a: assert property (interval_irq |-> st.stat[`WIT_ST_INTV])
    else $error("interval pulse without status bit");

  // Counter moves only on its selected clock
  wcnt_hold_a: assert property (oe && run && !wclk |=> st.wcnt == $past(st.wcnt))
    else $error("watch counter moved off its clock");

  // Every taken request is answered on the next cycle
  write_answer_a: assert property (wr_take |=> bvalid)
    else $error("write taken without response");

  read_answer_a: assert property (rd_take |=> rvalid)
    else $error("read taken without data");

  // Main scenarios
  watch_seen_c: cover property (watch_irq);
  intv_seen_c:  cover property (interval_irq && st.mode[`WIT_FWSRC_BIT]);
  brg_seen_c:   cover property (brg_tick ##[1:600] brg_tick);
  irq_clear_c:  cover property (irq ##[1:50] !irq);
  adjust_c:     cover property (oe && !run ##1 oe && run);

endmodule
`default_nettype wire

// ===== shared/wit_consts.svh
// Register offsets, field positions, reset values and counts of the watch/interval timer
`ifndef WIT_CONSTS_SVH
`define WIT_CONSTS_SVH

// Byte addresses of the registers
`define WIT_OFS_MODE    28'hFFFF680
`define WIT_OFS_PRSM    28'hFFFF684
`define WIT_OFS_CMP     28'hFFFF688
`define WIT_OFS_STAT    28'hFFFF68C
`define WIT_OFS_MASK    28'hFFFF690
`define WIT_OFS_COUNT   28'hFFFF694

// watch_mode_control fields
`define WIT_OE_BIT      0
`define WIT_RUN_BIT     1
`define WIT_WSEL_LO     2
`define WIT_WSEL_HI     3
`define WIT_ISEL_LO     4
`define WIT_ISEL_HI     6
`define WIT_FWSRC_BIT   7

// prescaler_mode fields
`define WIT_DIV_LO      0
`define WIT_DIV_HI      1
`define WIT_MCE_BIT     7

// Interrupt status and mask bit positions
`define WIT_ST_WATCH    0
`define WIT_ST_INTV     1

// Reset values
`define WIT_MODE_RST    8'h00
`define WIT_PRSM_RST    8'h00
`define WIT_CMP_RST     8'h00
`define WIT_MASK_RST    2'h0

// Counts: exponent of the shortest interval, exponent of the slow watch clock
`define WIT_INTV_BASE   4'h4
`define WIT_WSLOW_EXP   4'h9
`define WIT_WFAST_BITS  4'h4
`define WIT_WFULL_BITS  4'h5

// Bus answers
`define WIT_RESP_OKAY   2'h0
`define WIT_RESP_DECERR 2'h3

`endif

// ===== shared/wit_pkg.sv
// Types shared by the watch/interval timer design
package wit_pkg;

  // Write channel states, one-hot
  typedef enum logic [1:0] {
    WIT_WR_IDLE = 2'b01,
    WIT_WR_RESP = 2'b10
  } wit_wr_t;

  // Read channel states, one-hot
  typedef enum logic [1:0] {
    WIT_RD_IDLE = 2'b01,
    WIT_RD_DATA = 2'b10
  } wit_rd_t;

  // Whole state of the timer block
  typedef struct packed {
    logic [7:0]  mode;      // watch_mode_control
    logic [7:0]  prsm;      // prescaler_mode
    logic [7:0]  cmp;       // prescaler_compare
    logic [1:0]  stat;      // sticky interrupt status
    logic [1:0]  mask;      // interrupt mask
    logic [2:0]  src_div;   // 3-bit main clock prescaler
    logic [7:0]  cmp_cnt;   // 8-bit compare counter
    logic        brg_half;  // divide-by-two stage
    logic [2:0]  sub_sync;  // subclock synchroniser and edge stage
    logic [10:0] pre;       // 11-bit prescaler
    logic [4:0]  wcnt;      // 5-bit watch counter
    logic        watch_p;   // watch pulse
    logic        intv_p;    // interval pulse
    wit_wr_t     wr;
    wit_rd_t     rd;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } wit_state_t;

endpackage

// ===== bench/test_watch_interval_timer.sv
// Self-checking bench of the watch and interval timer, driven over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "wit_consts.svh"
module test_watch_interval_timer;
  import wit_pkg::*;
  // Bus and pin drivers
  logic        aclk      = 1'b0;
  logic        aresetn   = 1'b0;
  logic [27:0] awaddr    = 28'h0;
  logic [27:0] araddr    = 28'h0;
  logic [31:0] wdata     = 32'h0;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        subclk_in = 1'b0;
  logic [3:0]  sub_div   = 4'h0;
  // Design outputs
  logic        awready, wready, bvalid, arready, rvalid;
  logic        watch_irq, interval_irq, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  // Tallies
  int          n_errors    = 0;
  int          checks_done = 0;
  // Every mapped register, reset value zero
  logic [27:0] regs [6] = '{`WIT_OFS_MODE, `WIT_OFS_PRSM, `WIT_OFS_CMP, `WIT_OFS_STAT, `WIT_OFS_MASK, `WIT_OFS_COUNT};

  // 250 MHz system clock
  always #2 aclk = ~aclk;

  // Subclock with one rising edge every 16 system clocks
  always @(posedge aclk) begin
    sub_div   <= sub_div + 4'h1;
    subclk_in <= sub_div[3];
  end

  wit_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .subclk_in(subclk_in),
    .watch_irq(watch_irq), .interval_irq(interval_irq), .irq(irq)
  );

  // Compare one value and tally it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write: address and data offered together, held until taken, then the response
  task automatic wr(input logic [27:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    @(posedge aclk);
    while (!(awready && wready)) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    @(posedge aclk);
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // One read, comparing the masked data and the response
  task automatic rd(input logic [27:0] a, input logic [31:0] exp, input logic [31:0] msk, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    chk("rdata", exp, rdata & msk);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // Cycles between two pulses of one request line (1 = watch, 0 = interval)
  task automatic per(input logic which, input int exp);
    int n;
    n = 0;
    @(posedge aclk);
    while (!(which ? watch_irq : interval_irq) && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(which ? watch_irq : interval_irq) && n < 40000);
    chk(which ? "watch period" : "interval period", exp, n);
  endtask

  // Pulses seen on one request line over a span
  task automatic quiet(input logic which, input int cycles);
    int n;
    n = 0;
    repeat (cycles) begin
      @(posedge aclk);
      if ((which ? watch_irq : interval_irq) !== 1'b0) n++;
    end
    chk(which ? "watch pulses" : "interval pulses", 32'h0, n);
  endtask

  // Counts, then the verdict
  task automatic report_and_stop();
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    rd(28'hFFFF698, 32'h0, 32'hFFFFFFFF, `WIT_RESP_DECERR);
    wr(28'hFFFF698, 32'h1, `WIT_RESP_DECERR);
    wr(`WIT_OFS_MODE, 32'hFC, `WIT_RESP_OKAY);
    rd(`WIT_OFS_MODE, 32'hFC, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    wr(`WIT_OFS_COUNT, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    rd(`WIT_OFS_COUNT, 32'h0, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    // Divided main clock: tick every 2 system clocks
    wr(`WIT_OFS_PRSM, 32'h80, `WIT_RESP_OKAY);
    wr(`WIT_OFS_CMP, 32'h1, `WIT_RESP_OKAY);
    for (int v = 0; v < 8; v++) begin
      wr(`WIT_OFS_MODE, 32'h8C | (v << 4), `WIT_RESP_OKAY);
      wr(`WIT_OFS_MODE, 32'h8F | (v << 4), `WIT_RESP_OKAY);
      per(1'b0, 32 << v);
      if (v == 0) per(1'b1, 32);
      wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
    end
    // Watch periods of 2^5 and 2^13 ticks
    wr(`WIT_OFS_MODE, 32'h88, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h8B, `WIT_RESP_OKAY);
    per(1'b1, 64);
    wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h84, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h87, `WIT_RESP_OKAY);
    per(1'b1, 16384);
    // Longest watch period: no pulse at 2^13, counter at 16 slow ticks
    wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h80, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h83, `WIT_RESP_OKAY);
    quiet(1'b1, 16600);
    rd(`WIT_OFS_COUNT, 32'h00100000, 32'h001F0000, `WIT_RESP_OKAY);
    // Enable without run: prescaler only
    wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h8C, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h8D, `WIT_RESP_OKAY);
    rd(`WIT_OFS_COUNT, 32'h0, 32'h001F0000, `WIT_RESP_OKAY);
    quiet(1'b1, 200);
    per(1'b0, 32);
    wr(`WIT_OFS_MODE, 32'h8F, `WIT_RESP_OKAY);
    per(1'b1, 32);
    wr(`WIT_OFS_MODE, 32'h8D, `WIT_RESP_OKAY);
    rd(`WIT_OFS_COUNT, 32'h0, 32'h001F0000, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h8C, `WIT_RESP_OKAY);
    rd(`WIT_OFS_COUNT, 32'h0, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    quiet(1'b0, 200);
    // Every source divide with a compare value of 3
    for (int m = 0; m < 4; m++) begin
      wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
      wr(`WIT_OFS_PRSM, 32'h80 | m, `WIT_RESP_OKAY);
      wr(`WIT_OFS_CMP, 32'h3, `WIT_RESP_OKAY);
      wr(`WIT_OFS_MODE, 32'h8F, `WIT_RESP_OKAY);
      per(1'b0, 96 << m);
    end
    // Compare value zero divides by 256
    wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
    wr(`WIT_OFS_PRSM, 32'h80, `WIT_RESP_OKAY);
    wr(`WIT_OFS_CMP, 32'h0, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h8F, `WIT_RESP_OKAY);
    per(1'b0, 8192);
    // Main clock gated off
    wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
    wr(`WIT_OFS_PRSM, 32'h0, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h8F, `WIT_RESP_OKAY);
    quiet(1'b0, 300);
    // Subclock as the watch clock
    wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MASK, 32'h1, `WIT_RESP_OKAY);
    wr(`WIT_OFS_MODE, 32'h0F, `WIT_RESP_OKAY);
    per(1'b0, 256);
    per(1'b1, 256);
    // Sticky status, mask and the level request
    wr(`WIT_OFS_MODE, 32'h0, `WIT_RESP_OKAY);
    rd(`WIT_OFS_STAT, 32'h3, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    chk("irq watch unmasked", 32'h1, {31'h0, irq});
    wr(`WIT_OFS_MASK, 32'h0, `WIT_RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`WIT_OFS_MASK, 32'h2, `WIT_RESP_OKAY);
    rd(`WIT_OFS_MASK, 32'h2, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`WIT_OFS_STAT, 32'h1, `WIT_RESP_OKAY);
    rd(`WIT_OFS_STAT, 32'h2, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    chk("irq other set", 32'h1, {31'h0, irq});
    wr(`WIT_OFS_STAT, 32'h2, `WIT_RESP_OKAY);
    rd(`WIT_OFS_STAT, 32'h0, 32'hFFFFFFFF, `WIT_RESP_OKAY);
    chk("irq cleared", 32'h0, {31'h0, irq});
    report_and_stop();
  end

  // Watchdog over a span a little beyond the expected run
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
